// file: rtl/brake_seq.sv
/*
 * holding brake protection sequencer: apb slave with settings, sticky
 * event flags with mask, overheat and phase loss faults, brake release
 * output (active low pin) and motor power sequencing on servo enable.
 * assumes all inputs synchronous to pclk; speed is an unsigned rpm magnitude.
 */
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none
module brake_seq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        servo_enable_input_function,
    input  wire logic        motor_overheat_input_function,
    input  wire logic        input_phase_missing,
    input  wire logic        output_phase_missing,
    input  wire logic [15:0] filtered_motor_speed,
    output logic             holding_brake_output_n,
    output logic             motor_power_on,
    output logic             command_accept,
    output logic             motor_overheat_fault_code,
    output logic             phase_loss_fault,
    output logic             irq
);
    typedef struct packed {
        logic [15:0]                     phase_loss_enable_setting;
        logic [15:0]                     command_accept_delay_ms;
        logic [15:0]                     brake_zero_speed_threshold;
        logic [15:0]                     power_hold_after_lock_ms;
        logic [15:0]                     brake_lock_max_wait_ms;
        logic                            brake_fn;
        logic [brake_seq_pkg::EV_W-1:0]  irq_status;
        logic [brake_seq_pkg::EV_W-1:0]  irq_mask;
        brake_seq_pkg::seq_state_t       state;
        logic [15:0]                     div_cnt;
        logic [15:0]                     ms_cnt;
        logic                            en_d;
        logic                            overheat;
        logic                            phase_fault;
        logic                            brake_n;
        logic                            power;
        logic                            cmd_ok;
        logic [31:0]                     prdata;
        logic                            pready;
        logic                            pslverr;
        logic                            irq;
    } state_t;

    state_t cur;
    state_t next_s;

    // address is one of the mapped words
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= brake_seq_pkg::ADDR_SPEED_VIEW) && (a[1:0] == 2'b00);
    endfunction

    logic        tick;
    logic        wr;
    logic        rd;
    logic        rise;
    logic        fall;
    logic        pl_hit;
    localparam int EV_N = brake_seq_pkg::EV_W;
    logic [EV_N-1:0] ev;

    always_comb begin
        tick = (cur.div_cnt == brake_seq_pkg::MS_LAST);
        // access phase, one-cycle answer: pready high in the access cycle
        wr   = psel && penable && pwrite && cur.pready;
        rd   = psel && !penable && !pwrite;
        rise = servo_enable_input_function && !cur.en_d;
        fall = !servo_enable_input_function && cur.en_d;
        pl_hit = (cur.phase_loss_enable_setting[brake_seq_pkg::PL_OUTPUT_BIT]
                  && output_phase_missing)
              || (cur.phase_loss_enable_setting[brake_seq_pkg::PL_INPUT_BIT]
                  && input_phase_missing);
    end

    // next state
    always_comb begin
        next_s = cur;
        ev = '0;
        next_s.en_d = servo_enable_input_function;
        next_s.div_cnt = tick ? 16'h0000 : cur.div_cnt + 16'h0001;
        if (tick && cur.ms_cnt != 16'hFFFF)
            next_s.ms_cnt = cur.ms_cnt + 16'h0001;

        // apb: answer in the cycle after setup, pready one cycle
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !mapped(paddr);
        if (rd) begin
            case (paddr)
                brake_seq_pkg::ADDR_PHASE_LOSS: next_s.prdata = {16'h0000, cur.phase_loss_enable_setting};
                brake_seq_pkg::ADDR_CMD_DELAY:  next_s.prdata = {16'h0000, cur.command_accept_delay_ms};
                brake_seq_pkg::ADDR_ZERO_SPEED: next_s.prdata = {16'h0000, cur.brake_zero_speed_threshold};
                brake_seq_pkg::ADDR_HOLD_TIME:  next_s.prdata = {16'h0000, cur.power_hold_after_lock_ms};
                brake_seq_pkg::ADDR_MAX_WAIT:   next_s.prdata = {16'h0000, cur.brake_lock_max_wait_ms};
                brake_seq_pkg::ADDR_CONTROL:    next_s.prdata = {31'h0, cur.brake_fn};
                brake_seq_pkg::ADDR_STATUS:     next_s.prdata = {26'h0, cur.state};
                brake_seq_pkg::ADDR_IRQ_STATUS: next_s.prdata = {28'h0, cur.irq_status};
                brake_seq_pkg::ADDR_IRQ_MASK:   next_s.prdata = {28'h0, cur.irq_mask};
                brake_seq_pkg::ADDR_SPEED_VIEW: next_s.prdata = {16'h0000, filtered_motor_speed};
                default:                        next_s.prdata = 32'h0000_0000;
            endcase
        end else if (psel && !penable) begin
            next_s.prdata = 32'h0000_0000;
        end

        // register writes take effect at once
        if (wr) begin
            case (paddr)
                brake_seq_pkg::ADDR_PHASE_LOSS: next_s.phase_loss_enable_setting = pwdata[15:0];
                brake_seq_pkg::ADDR_CMD_DELAY:  next_s.command_accept_delay_ms = pwdata[15:0];
                brake_seq_pkg::ADDR_ZERO_SPEED: next_s.brake_zero_speed_threshold = pwdata[15:0];
                brake_seq_pkg::ADDR_HOLD_TIME:  next_s.power_hold_after_lock_ms = pwdata[15:0];
                brake_seq_pkg::ADDR_MAX_WAIT:   next_s.brake_lock_max_wait_ms = pwdata[15:0];
                brake_seq_pkg::ADDR_CONTROL: begin
                    next_s.brake_fn = pwdata[brake_seq_pkg::CTL_BRAKE_FN];
                    // clearing faults only sticks once the cause is gone
                    if (pwdata[brake_seq_pkg::CTL_FAULT_CLR]) begin
                        next_s.overheat = 1'b0;
                        next_s.phase_fault = 1'b0;
                    end
                end
                brake_seq_pkg::ADDR_IRQ_STATUS:
                    next_s.irq_status = cur.irq_status & ~pwdata[EV_N-1:0];
                brake_seq_pkg::ADDR_IRQ_MASK:   next_s.irq_mask = pwdata[EV_N-1:0];
                default: ;
            endcase
        end

        // faults: level causes re-raise every cycle
        if (motor_overheat_input_function) begin
            next_s.overheat = 1'b1;
            ev[brake_seq_pkg::EV_OVERHEAT] = !cur.overheat;
        end
        if (pl_hit) begin
            next_s.phase_fault = 1'b1;
            ev[brake_seq_pkg::EV_PHASE_LOSS] = !cur.phase_fault;
        end

        // sequencer
        case (cur.state)
            brake_seq_pkg::ST_IDLE: begin
                next_s.brake_n = 1'b1;
                next_s.power = 1'b0;
                next_s.cmd_ok = 1'b0;
                if (servo_enable_input_function && !next_s.overheat && !next_s.phase_fault) begin
                    next_s.state = brake_seq_pkg::ST_RUN;
                    next_s.power = 1'b1;
                    next_s.brake_n = !cur.brake_fn;
                    next_s.ms_cnt = 16'h0000;
                    next_s.div_cnt = 16'h0000;
                end
            end
            brake_seq_pkg::ST_RUN: begin
                next_s.brake_n = !cur.brake_fn;
                if (cur.ms_cnt >= cur.command_accept_delay_ms)
                    next_s.cmd_ok = 1'b1;
                if (!servo_enable_input_function) begin
                    next_s.cmd_ok = 1'b0;
                    next_s.ms_cnt = 16'h0000;
                    next_s.div_cnt = 16'h0000;
                    if (filtered_motor_speed < brake_seq_pkg::STATIC_SPEED_RPM) begin
                        next_s.brake_n = 1'b1;
                        next_s.state = brake_seq_pkg::ST_HOLD;
                        ev[brake_seq_pkg::EV_LOCKED] = 1'b1;
                    end else begin
                        next_s.state = brake_seq_pkg::ST_DYN_WAIT;
                    end
                end
            end
            brake_seq_pkg::ST_DYN_WAIT: begin
                if (filtered_motor_speed < cur.brake_zero_speed_threshold
                    || cur.ms_cnt > cur.brake_lock_max_wait_ms) begin
                    next_s.brake_n = 1'b1;
                    next_s.state = brake_seq_pkg::ST_HOLD;
                    next_s.ms_cnt = 16'h0000;
                    next_s.div_cnt = 16'h0000;
                    next_s.cmd_ok = 1'b1;   // marks dynamic hold, cleared below
                    ev[brake_seq_pkg::EV_LOCKED] = 1'b1;
                end
            end
            brake_seq_pkg::ST_HOLD: begin
                next_s.cmd_ok = cur.cmd_ok;
                // dynamic path uses its fixed 50 ms; static uses the setting, or none while brake_fn is clear
                if ((cur.cmd_ok && cur.ms_cnt >= brake_seq_pkg::DYN_HOLD_MS)
                    || (!cur.cmd_ok && (!cur.brake_fn
                        || cur.ms_cnt >= cur.power_hold_after_lock_ms))) begin
                    next_s.power = 1'b0;
                    next_s.cmd_ok = 1'b0;
                    next_s.state = brake_seq_pkg::ST_IDLE;
                    ev[brake_seq_pkg::EV_POWER_OFF] = 1'b1;
                end
            end
            brake_seq_pkg::ST_FAULT: begin
                next_s.brake_n = 1'b1;
                next_s.power = 1'b0;
                next_s.cmd_ok = 1'b0;
                if (!next_s.overheat && !next_s.phase_fault && !servo_enable_input_function)
                    next_s.state = brake_seq_pkg::ST_IDLE;
            end
            default: next_s.state = brake_seq_pkg::ST_IDLE;
        endcase

        // a fault drops power and locks the brake at once
        if (next_s.overheat || next_s.phase_fault) begin
            next_s.state = brake_seq_pkg::ST_FAULT;
            next_s.power = 1'b0;
            next_s.brake_n = 1'b1;
            next_s.cmd_ok = 1'b0;
        end

        // set beats clear on the same cycle
        next_s.irq_status = next_s.irq_status | ev;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);
    end

    // command accept output is only valid while running
    logic cmd_run;
    assign cmd_run = cur.cmd_ok && (cur.state == brake_seq_pkg::ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.phase_loss_enable_setting  <= brake_seq_pkg::RST_PHASE_LOSS;
            cur.command_accept_delay_ms    <= brake_seq_pkg::RST_CMD_DELAY;
            cur.brake_zero_speed_threshold <= brake_seq_pkg::RST_ZERO_SPEED;
            cur.power_hold_after_lock_ms   <= brake_seq_pkg::RST_HOLD_TIME;
            cur.brake_lock_max_wait_ms     <= brake_seq_pkg::RST_MAX_WAIT;
            cur.brake_fn                   <= 1'b1;
            cur.state                      <= brake_seq_pkg::ST_IDLE;
            cur.brake_n                    <= 1'b1;   // brake held at power-up
        end else begin
            cur <= next_s;
        end
    end

    // command accept register kept separate so it drops with state change
    logic cmd_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cmd_q <= 1'b0;
        else
            cmd_q <= cmd_run && next_s.state == brake_seq_pkg::ST_RUN;
    end

    assign prdata                    = cur.prdata;
    assign pready                    = cur.pready;
    assign pslverr                   = cur.pslverr;
    assign holding_brake_output_n    = cur.brake_n;      // low = released
    assign motor_power_on            = cur.power;
    assign command_accept            = cmd_q;
    assign motor_overheat_fault_code = cur.overheat;
    assign phase_loss_fault          = cur.phase_fault;
    assign irq                       = cur.irq;

    // assertions
    property p_overheat;
        @(posedge pclk) disable iff (!presetn)
        motor_overheat_input_function |=> motor_overheat_fault_code && !motor_power_on;
    endproperty
    a_overheat: assert property (p_overheat) else $error("overheat not raised");

    property p_out_phase;
        @(posedge pclk) disable iff (!presetn)
        (output_phase_missing && phase_loss_enable_setting_bit(0)) |=> phase_loss_fault;
    endproperty
    a_out_phase: assert property (p_out_phase) else $error("output phase loss missed");

    property p_no_phase;
        @(posedge pclk) disable iff (!presetn)
        (cur.phase_loss_enable_setting == 16'h0000 && !cur.phase_fault
         && !(psel && penable && pwrite)) |=> !phase_loss_fault;
    endproperty
    a_no_phase: assert property (p_no_phase) else $error("phase fault while disabled");

    property p_lock_when_off;
        @(posedge pclk) disable iff (!presetn)
        !motor_power_on |-> holding_brake_output_n;
    endproperty
    a_lock_when_off: assert property (p_lock_when_off) else $error("brake open unpowered");

    property p_enable;
        @(posedge pclk) disable iff (!presetn)
        (cur.state == brake_seq_pkg::ST_IDLE && servo_enable_input_function
         && cur.brake_fn && !next_s.overheat && !next_s.phase_fault)
        |=> motor_power_on && !holding_brake_output_n;
    endproperty
    a_enable: assert property (p_enable) else $error("enable not applied together");

    property p_static;
        @(posedge pclk) disable iff (!presetn)
        (cur.state == brake_seq_pkg::ST_RUN && !servo_enable_input_function
         && filtered_motor_speed < brake_seq_pkg::STATIC_SPEED_RPM && !next_s.overheat
         && !next_s.phase_fault) |=> holding_brake_output_n && motor_power_on;
    endproperty
    a_static: assert property (p_static) else $error("static lock late");

    property p_cmd;
        @(posedge pclk) disable iff (!presetn)
        command_accept |-> $past(cur.ms_cnt, 1) >= cur.command_accept_delay_ms;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command accepted early");

    property p_dyn;
        @(posedge pclk) disable iff (!presetn)
        (cur.state == brake_seq_pkg::ST_DYN_WAIT && !next_s.overheat && !next_s.phase_fault
         && filtered_motor_speed < cur.brake_zero_speed_threshold)
        |=> holding_brake_output_n && cur.state == brake_seq_pkg::ST_HOLD;
    endproperty
    a_dyn: assert property (p_dyn) else $error("dynamic lock missed");

    property p_in_phase;
        @(posedge pclk) disable iff (!presetn)
        (input_phase_missing && phase_loss_enable_setting_bit(brake_seq_pkg::PL_INPUT_BIT))
        |=> phase_loss_fault;
    endproperty
    a_in_phase: assert property (p_in_phase) else $error("input phase loss missed");

    property p_max_wait;
        @(posedge pclk) disable iff (!presetn)
        (cur.state == brake_seq_pkg::ST_DYN_WAIT && !next_s.overheat && !next_s.phase_fault
         && cur.ms_cnt > cur.brake_lock_max_wait_ms)
        |=> holding_brake_output_n && cur.state == brake_seq_pkg::ST_HOLD;
    endproperty
    a_max_wait: assert property (p_max_wait) else $error("max wait lock missed");

    property p_dyn_hold;
        @(posedge pclk) disable iff (!presetn)
        (cur.state == brake_seq_pkg::ST_HOLD && cur.cmd_ok && !next_s.overheat
         && !next_s.phase_fault && cur.ms_cnt < brake_seq_pkg::DYN_HOLD_MS) |=> motor_power_on;
    endproperty
    a_dyn_hold: assert property (p_dyn_hold) else $error("dynamic hold cut short");

    property p_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && paddr == brake_seq_pkg::ADDR_PHASE_LOSS)
        |=> {16'h0000, cur.phase_loss_enable_setting} == ($past(pwdata) & 32'h0000_FFFF);
    endproperty
    a_write: assert property (p_write) else $error("setting write lost");

    function automatic logic phase_loss_enable_setting_bit(input int b);
        phase_loss_enable_setting_bit = cur.phase_loss_enable_setting[b];
    endfunction

    c_static: cover property (@(posedge pclk) disable iff (!presetn)
        cur.state == brake_seq_pkg::ST_RUN ##1 cur.state == brake_seq_pkg::ST_HOLD);
    c_dyn: cover property (@(posedge pclk) disable iff (!presetn)
        cur.state == brake_seq_pkg::ST_DYN_WAIT ##1 cur.state == brake_seq_pkg::ST_HOLD);
    c_fault: cover property (@(posedge pclk) disable iff (!presetn)
        cur.state == brake_seq_pkg::ST_FAULT);
    c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
        cur.state == brake_seq_pkg::ST_DYN_WAIT && cur.ms_cnt > cur.brake_lock_max_wait_ms);
endmodule // brake_seq
`default_nettype wire

// file: pkg/brake_seq_pkg.sv
/*
 * constants for the holding brake protection sequencer: apb register map,
 * reset values, field positions, timing counts and the sequencer state enum.
 * assumes a 40 MHz pclk and a 32-bit apb bus.
 */
`default_nettype none
package brake_seq_pkg;
    // apb word offsets, chosen for this block
    localparam logic [7:0] ADDR_PHASE_LOSS   = 8'h00;
    localparam logic [7:0] ADDR_CMD_DELAY    = 8'h04;
    localparam logic [7:0] ADDR_ZERO_SPEED   = 8'h08;
    localparam logic [7:0] ADDR_HOLD_TIME    = 8'h0C;
    localparam logic [7:0] ADDR_MAX_WAIT     = 8'h10;
    localparam logic [7:0] ADDR_CONTROL      = 8'h14;
    localparam logic [7:0] ADDR_STATUS       = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h20;
    localparam logic [7:0] ADDR_SPEED_VIEW   = 8'h24;

    // reset values
    localparam logic [15:0] RST_PHASE_LOSS   = 16'h0003;
    localparam logic [15:0] RST_CMD_DELAY    = 16'h00FA;
    localparam logic [15:0] RST_ZERO_SPEED   = 16'h001E;
    localparam logic [15:0] RST_HOLD_TIME    = 16'h0096;
    localparam logic [15:0] RST_MAX_WAIT     = 16'h01F4;

    // field positions
    localparam int PL_OUTPUT_BIT  = 0;
    localparam int PL_INPUT_BIT   = 1;
    localparam int CTL_BRAKE_FN   = 0;
    localparam int CTL_FAULT_CLR  = 1;
    localparam int EV_OVERHEAT    = 0;
    localparam int EV_PHASE_LOSS  = 1;
    localparam int EV_LOCKED      = 2;
    localparam int EV_POWER_OFF   = 3;
    localparam int EV_W           = 4;

    // static versus dynamic choice, and fixed dynamic hold time
    localparam logic [15:0] STATIC_SPEED_RPM = 16'h0014;
    localparam logic [15:0] DYN_HOLD_MS      = 16'h0032;

    // millisecond tick from 40 MHz
    localparam int CLK_HZ       = 40_000_000;
    localparam int TICK_PER_S   = 1_000;
    localparam int MS_CYCLES    = CLK_HZ / TICK_PER_S;
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    typedef enum logic [5:0] {
        ST_IDLE     = 6'b00_0001,
        ST_RUN      = 6'b00_0010,
        ST_DYN_WAIT = 6'b00_0100,
        ST_HOLD     = 6'b00_1000,
        ST_FAULT    = 6'b01_0000,
        ST_SPARE    = 6'b10_0000
    } seq_state_t;
endpackage : brake_seq_pkg
`default_nettype wire

// file: test/host_ctrl_model.sv
/*
 * host motion controller model: drives servo enable and filtered speed.
 * assumes a shared pclk; it changes its outputs only just after rising edges.
 */
`default_nettype none
module host_ctrl_model (
    input  wire logic        pclk,
    input  wire logic        command_accept,
    output logic             servo_enable_input_function,
    output logic      [15:0] filtered_motor_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    int cmds_sent;
    // idle at power-up: drive disabled, shaft still
    initial begin
        servo_enable_input_function = 1'b0;
        filtered_motor_speed = 16'h0000;
        cmds_sent = 0;
    end
    // motion commands only once accepted, never inside the delay window
    always @(posedge pclk) begin
        if (command_accept === 1'b1) begin
            cmds_sent <= cmds_sent + 1;
        end
    end
    // enable and speed move together so the speed seen at disable is exact
    task automatic drive(input logic en, input logic [15:0] spd);
        @(posedge pclk);
        servo_enable_input_function <= en;
        filtered_motor_speed <= spd;
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// file: test/tb_top.sv
/*
 * self-checking bench for brake_seq: apb master, register model, fault,
 * interrupt and brake sequence scenarios against the host model.
 * assumes a 40 MHz pclk and the fixed 40000-cycle millisecond tick.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, rnd_state;
    logic        servo_enable_input_function, motor_overheat_input_function;
    logic        input_phase_missing, output_phase_missing, holding_brake_output_n;
    logic        motor_power_on, command_accept, motor_overheat_fault_code;
    logic        phase_loss_fault, irq;
    logic [15:0] filtered_motor_speed;
    int          fails, comparisons;
    int          exp_reg[$];

    brake_seq i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .servo_enable_input_function, .motor_overheat_input_function,
        .input_phase_missing, .output_phase_missing, .filtered_motor_speed,
        .holding_brake_output_n, .motor_power_on, .command_accept,
        .motor_overheat_fault_code, .phase_loss_fault, .irq);
    host_ctrl_model i_host (.pclk, .command_accept, .servo_enable_input_function,
        .filtered_motor_speed);

    // 25 ns clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        rnd_state ^= rnd_state << 13;
        rnd_state ^= rnd_state >> 17;
        rnd_state ^= rnd_state << 5;
        return rnd_state;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one apb transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        q = prdata;
        err = pslverr;
        chk("pready", 32'h0000_0001, {31'h0, pready});
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // settings writes also update the model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a < 8'h14) exp_reg[a >> 2] = int'(d[15:0]);
    endtask

    function automatic logic outv(input int w);
        case (w)
            0: return holding_brake_output_n;
            1: return motor_power_on;
            2: return command_accept;
            3: return motor_overheat_fault_code;
            4: return phase_loss_fault;
            default: return irq;
        endcase
    endfunction

    // bounded wait for an output level, then compare
    task automatic wait_out(input string n, input int w, input logic v, input int lim);
        int c;
        c = 0;
        while (outv(w) !== v && c < lim) begin
            @(posedge pclk);
            c++;
        end
        chk(n, {31'h0, v}, {31'h0, outv(w)});
    endtask

    // reset also reloads the register model
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        exp_reg = '{3, 250, 30, 150, 500};
    endtask

    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog sized to the two one-millisecond waits plus margin
    initial begin
        repeat (100_000) @(posedge pclk);
        fails++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {motor_overheat_input_function, input_phase_missing, output_phase_missing} = '0;
        {fails, comparisons} = '0;
        rnd_state = 32'h0000_80a5;
        do_reset();
        chk("brake_n_reset", 1, holding_brake_output_n);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk("setting_reset", exp_reg[i], q);
        end
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk("unmapped_err", 1, err);
        wr(brake_seq_pkg::ADDR_ZERO_SPEED, rnd() & 32'h0000_7fff);
        apb(1'b0, brake_seq_pkg::ADDR_ZERO_SPEED, 32'h0000_0000);
        chk("zero_speed_rw", exp_reg[2], q);
        wr(brake_seq_pkg::ADDR_ZERO_SPEED, 32'h0000_001e);
        // overheat: masked first, then unmasked, then cleared
        motor_overheat_input_function <= 1'b1;
        wait_out("overheat_fault", 3, 1'b1, 10);
        chk("irq_masked", 0, irq);
        wr(brake_seq_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        wait_out("irq_raised", 5, 1'b1, 10);
        apb(1'b0, brake_seq_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
        chk("irq_status_ovh", 1, q[0]);
        motor_overheat_input_function <= 1'b0;
        wr(brake_seq_pkg::ADDR_CONTROL, 32'h0000_0003);
        wr(brake_seq_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
        wait_out("irq_cleared", 5, 1'b0, 10);
        wait_out("overheat_clr", 3, 1'b0, 10);
        // static sequence with default delay: commands still refused
        i_host.drive(1'b1, 16'h0000);
        wait_out("power_on", 1, 1'b1, 3);
        chk("brake_release", 0, holding_brake_output_n);
        repeat (20) @(posedge pclk);
        chk("cmd_blocked", 0, command_accept);
        i_host.drive(1'b0, 16'(rnd() % 20));
        wait_out("static_lock", 0, 1'b1, 3);
        chk("static_hold", 1, motor_power_on);
        do_reset();
        wr(brake_seq_pkg::ADDR_CMD_DELAY, 32'h0000_0000);
        wr(brake_seq_pkg::ADDR_HOLD_TIME, 32'h0000_0001);
        i_host.drive(1'b1, 16'h0000);
        wait_out("cmd_accept", 2, 1'b1, 10);
        i_host.drive(1'b0, 16'h0005);
        wait_out("static_lock2", 0, 1'b1, 3);
        repeat (100) @(posedge pclk);
        chk("hold_power", 1, motor_power_on);
        wait_out("hold_off", 1, 1'b0, 41_000);
        // dynamic sequence ended by the zero-speed threshold
        q = 32'h0000_001e + (rnd() % 1000);
        i_host.drive(1'b1, q[15:0]);
        wait_out("dyn_power", 1, 1'b1, 3);
        i_host.drive(1'b0, q[15:0]);
        repeat (20) @(posedge pclk);
        chk("dyn_released", 0, holding_brake_output_n);
        i_host.drive(1'b0, 16'd29);
        wait_out("dyn_lock", 0, 1'b1, 5);
        repeat (100) @(posedge pclk);
        chk("dyn_power_held", 1, motor_power_on);
        do_reset();
        // dynamic sequence ended by the max wait
        wr(brake_seq_pkg::ADDR_MAX_WAIT, 32'h0000_0000);
        i_host.drive(1'b1, 16'd500);
        wait_out("dyn2_power", 1, 1'b1, 3);
        i_host.drive(1'b0, 16'd500);
        wait_out("dyn_timeout", 0, 1'b1, 41_000);
        do_reset();
        // brake function unassigned: pin stays locked, no hold time
        wr(brake_seq_pkg::ADDR_CONTROL, 32'h0000_0000);
        wr(brake_seq_pkg::ADDR_HOLD_TIME, 32'h0000_0005);
        i_host.drive(1'b1, 16'h0000);
        wait_out("nofn_power", 1, 1'b1, 3);
        chk("nofn_brake", 1, holding_brake_output_n);
        i_host.drive(1'b0, 16'h0000);
        wait_out("nofn_off", 1, 1'b0, 5);
        // phase loss: disabled setting, then input and output protection
        wr(brake_seq_pkg::ADDR_PHASE_LOSS, 32'h0000_0000);
        {input_phase_missing, output_phase_missing} <= 2'b11;
        repeat (5) @(posedge pclk);
        chk("pl_disabled", 0, phase_loss_fault);
        output_phase_missing <= 1'b0;
        wr(brake_seq_pkg::ADDR_PHASE_LOSS, 32'h0000_0002);
        wait_out("pl_input", 4, 1'b1, 5);
        input_phase_missing <= 1'b0;
        wr(brake_seq_pkg::ADDR_CONTROL, 32'h0000_0003);
        wait_out("pl_clear", 4, 1'b0, 5);
        wr(brake_seq_pkg::ADDR_PHASE_LOSS, 32'h0000_0001);
        i_host.drive(1'b1, 16'h0000);
        wait_out("pl_power", 1, 1'b1, 3);
        output_phase_missing <= 1'b1;
        wait_out("pl_output", 4, 1'b1, 5);
        wait_out("pl_cut", 1, 1'b0, 3);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
